// >>> hdl/cps_as_if.sv
// signals between the supervisor and its auto-switch sequencer
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface cps_as_if;
	logic	enable;
	logic	attached;
	logic	connected;
	logic	discharge_req;
	logic	present_std;
	logic	fallback_evt;
	modport ctrl (
		output	enable,
		output	attached,
		output	connected,
		input	discharge_req,
		input	present_std,
		input	fallback_evt
	);
	modport fsm (
		input	enable,
		input	attached,
		input	connected,
		output	discharge_req,
		output	present_std,
		output	fallback_evt
	);
endinterface
`default_nettype wire

// >>> hdl/cps_autosw.sv
// sequencer that falls back from charging-data to standard-data presentation
// assumes enable, attached and connected are synchronous levels
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.svh"
module cps_autosw #(
	parameter int unsigned NOCONN_CYCLES = `CPS_NOCONN_CYCLES,
	parameter int unsigned DISCH_CYCLES  = `CPS_DISCH_CYCLES
) (
	input	wire logic	clk,
	input	wire logic	rstn,
	cps_as_if.fsm		bus
);
	localparam int unsigned MAXC = (NOCONN_CYCLES > DISCH_CYCLES) ? NOCONN_CYCLES : DISCH_CYCLES;
	localparam int unsigned CW = $clog2(MAXC + 1);
	localparam logic [CW-1:0] NOCONN_LAST = CW'(NOCONN_CYCLES - 1);
	localparam logic [CW-1:0] DISCH_LAST = CW'(DISCH_CYCLES - 1);

	cps_pkg::cps_as_e	state;
	cps_pkg::cps_as_e	next_state;
	logic	[CW-1:0]	cnt;
	wire			stay = bus.enable & bus.attached;

	always_comb begin
		next_state = state;
		case (state)
		cps_pkg::AS_IDLE:
			if (stay) next_state = cps_pkg::AS_WATCH;
		cps_pkg::AS_WATCH:
			if (!stay) next_state = cps_pkg::AS_IDLE;
			else if (bus.connected) next_state = cps_pkg::AS_DONE;
			else if (cnt == NOCONN_LAST) next_state = cps_pkg::AS_DISCH;
		cps_pkg::AS_DISCH:
			if (!bus.enable) next_state = cps_pkg::AS_IDLE;
			else if (cnt == DISCH_LAST) next_state = cps_pkg::AS_STD;
		cps_pkg::AS_STD:
			if (!stay) next_state = cps_pkg::AS_IDLE;
			else if (bus.connected) next_state = cps_pkg::AS_DONE;
		cps_pkg::AS_DONE:
			if (!stay) next_state = cps_pkg::AS_IDLE;
		default: next_state = cps_pkg::AS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= cps_pkg::AS_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= (next_state != state) ? '0 : cnt + CW'(cnt != '1);
		end
	end

	assign bus.discharge_req = (state == cps_pkg::AS_DISCH);
	assign bus.present_std = (state == cps_pkg::AS_DISCH) || (state == cps_pkg::AS_STD);
	assign bus.fallback_evt = (state == cps_pkg::AS_WATCH) && (next_state == cps_pkg::AS_DISCH);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_noconn;
		state == cps_pkg::AS_WATCH && cnt == NOCONN_LAST && stay && !bus.connected;
	endsequence
	AST_AS_DETECT: assert property (s_noconn |-> bus.fallback_evt ##1 bus.discharge_req)
		else $error("missed fallback after no data connection");
	AST_AS_RETURN: assert property (state == cps_pkg::AS_STD && stay && bus.connected
		|=> state == cps_pkg::AS_DONE && !bus.discharge_req && !bus.present_std)
		else $error("no clean return after data connection");
endmodule
`default_nettype wire

// >>> hdl/cps_deglitch.sv
// deglitch filter: output rises once the input has stayed high long enough
// assumes a synchronous input and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.svh"
module cps_deglitch #(
	parameter int unsigned CYCLES = `CPS_DEGLITCH_CYCLES
) (
	input	wire logic	clk,
	input	wire logic	rstn,
	input	wire logic	din,
	output	var logic	dout
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic	[CW-1:0]	cnt;

	always_ff @(posedge clk) begin
		if (!rstn || !din) begin
			cnt <= '0;
			dout <= 1'b0;
		end else if (cnt == LAST)
			dout <= 1'b1;
		else
			cnt <= cnt + CW'(1);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_DG_SHORT: assert property ($rose(din) && CYCLES > 1 |=> !dout)
		else $error("deglitch passed a one-cycle limit");
	AST_DG_RELEASE: assert property (!din |=> !dout)
		else $error("deglitch held after input cleared");
	AST_DG_FULL: assert property ($rose(dout) |-> $past(din) && $past(cnt) == LAST)
		else $error("deglitch fired before the full interval");
endmodule
`default_nettype wire

// >>> hdl/cps_pkg.sv
// types and mode decoding of the charge port supervisor
// assumes nothing of its surroundings
`default_nettype none
package cps_pkg;

	typedef enum logic [2:0] {
		MODE_DISCHARGE,
		MODE_CHARGER_AUTO,
		MODE_STD_DATA_1,
		MODE_CHARGER_SHORTED,
		MODE_CHARGER_DIVIDER,
		MODE_STD_DATA_2,
		MODE_CHARGING_DATA
	} cps_mode_e;

	typedef enum logic [1:0] {
		SW_OFF,
		SW_ON,
		SW_LIMIT,
		SW_THERMAL
	} cps_sw_e;

	typedef enum logic [2:0] {
		AS_IDLE,
		AS_WATCH,
		AS_DISCH,
		AS_STD,
		AS_DONE
	} cps_as_e;

	// pins ordered {mode_select_0, mode_select_1, mode_select_2, limit_threshold_select}
	function automatic cps_mode_e cps_decode_mode(input logic [3:0] code);
		case (code[3:1])
		3'h0: cps_decode_mode = MODE_DISCHARGE;
		3'h1, 3'h3: cps_decode_mode = MODE_CHARGER_AUTO;
		3'h2, 3'h6: cps_decode_mode = MODE_STD_DATA_1;
		3'h4: cps_decode_mode = MODE_CHARGER_SHORTED;
		3'h5: cps_decode_mode = MODE_CHARGER_DIVIDER;
		default: cps_decode_mode = code[0] ? MODE_CHARGING_DATA : MODE_STD_DATA_2;
		endcase
	endfunction

endpackage
`default_nettype wire

// >>> hdl/cps_regs.svh
// register offsets, field positions, reset values and counts of the supervisor
// assumes a word-addressed avalon slave with 32-bit data
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

`define CPS_REG_CTRL		4'h0
`define CPS_REG_STATUS		4'h1
`define CPS_REG_INT_STATUS	4'h2
`define CPS_REG_INT_MASK	4'h3

`define CPS_CTRL_EN_BIT		0
`define CPS_CTRL_EN_RESET	1'b1
`define CPS_INT_MASK_RESET	5'h00

`define CPS_INT_FAULT		0
`define CPS_INT_THERMAL		1
`define CPS_INT_FALLBACK	2
`define CPS_INT_SUPPLY		3
`define CPS_INT_MODE		4
`define CPS_INT_W		5

`define CPS_DEGLITCH_CYCLES	64
`define CPS_NOCONN_CYCLES	2000
`define CPS_DISCH_CYCLES	1000

`endif

// >>> hdl/cps_supervisor.sv
// supervisory logic of a charging-port power switch with avalon registers
// assumes synchronous comparator inputs and one 10 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.svh"
module cps_supervisor #(
	parameter int unsigned DEGLITCH_CYCLES = `CPS_DEGLITCH_CYCLES,
	parameter int unsigned NOCONN_CYCLES   = `CPS_NOCONN_CYCLES,
	parameter int unsigned DISCH_CYCLES    = `CPS_DISCH_CYCLES
) (
	input	wire logic		clk,
	input	wire logic		rstn,
	input	wire logic [3:0]	avs_address,
	input	wire logic		avs_read,
	input	wire logic		avs_write,
	input	wire logic [31:0]	avs_writedata,
	output	var logic [31:0]	avs_readdata,
	output	var logic		avs_waitrequest,
	output	var logic		irq,
	input	wire logic		mode_select_0,
	input	wire logic		mode_select_1,
	input	wire logic		mode_select_2,
	input	wire logic		limit_threshold_select,
	input	wire logic		overcurrent,
	input	wire logic		temp_lower_hot,
	input	wire logic		temp_upper_hot,
	input	wire logic		supply_above_on,
	input	wire logic		supply_below_off,
	input	wire logic		port_attached,
	input	wire logic		data_connected,
	output	var logic		switch_on,
	output	var logic		current_limiting,
	output	var logic		upper_current_threshold,
	output	var logic		vbus_discharge,
	output	var logic [2:0]		port_mode,
	output	var logic		fault_n_out,
	output	var logic		fault_n_oe_n
);
	localparam int unsigned DW = $clog2(DISCH_CYCLES + 1);
	localparam logic [DW-1:0] DISCH_LOAD = DW'(DISCH_CYCLES);
	localparam int unsigned IW = `CPS_INT_W;

	cps_pkg::cps_mode_e	mode;
	cps_pkg::cps_mode_e	mode_q;
	cps_pkg::cps_sw_e	sw_state;
	cps_pkg::cps_sw_e	next_sw;
	logic			power_ok;
	logic			ctrl_en;
	logic	[DW-1:0]	disch_cnt;
	logic	[IW-1:0]	int_status;
	logic	[IW-1:0]	int_mask;
	logic			cl_long;

	cps_as_if as_bus ();

	// mode and threshold decode
	wire		next_power_ok;
	wire		pair_q;
	wire		pair_now;
	wire		mode_chg;
	wire		next_disch;
	wire		allowed;
	wire		ot_trip;
	wire		next_fault;
	wire		next_upper;
	wire	[IW-1:0]	events;
	wire	[IW-1:0]	clr_bits;
	wire	[IW-1:0]	next_int;
	wire	[31:0]	status_word;
	wire	[31:0]	rd_mux;
	wire		acc;
	wire		wr;
	wire		rd_int;

	assign mode = cps_pkg::cps_decode_mode({mode_select_0, mode_select_1,
		mode_select_2, limit_threshold_select});
	assign next_upper = (mode == cps_pkg::MODE_CHARGER_AUTO) ||
		((mode != cps_pkg::MODE_DISCHARGE) && limit_threshold_select);

	assign next_power_ok = supply_below_off ? 1'b0 :
		supply_above_on ? 1'b1 : power_ok;

	assign pair_q = (mode_q == cps_pkg::MODE_STD_DATA_2) ||
		(mode_q == cps_pkg::MODE_CHARGING_DATA);
	assign pair_now = (mode == cps_pkg::MODE_STD_DATA_2) ||
		(mode == cps_pkg::MODE_CHARGING_DATA);
	assign mode_chg = (mode != mode_q) && !(pair_q && pair_now);

	assign next_disch = (disch_cnt != '0) || mode_chg ||
		(mode == cps_pkg::MODE_DISCHARGE) || as_bus.discharge_req;

	assign allowed = power_ok && ctrl_en && !next_disch;

	assign ot_trip = temp_upper_hot ||
		(temp_lower_hot && (sw_state == cps_pkg::SW_LIMIT));

	assign as_bus.enable = (mode == cps_pkg::MODE_CHARGING_DATA) && power_ok;
	assign as_bus.attached = port_attached;
	assign as_bus.connected = data_connected;

	cps_autosw #(
		.NOCONN_CYCLES	(NOCONN_CYCLES),
		.DISCH_CYCLES	(DISCH_CYCLES)
	) u_autosw (
		.clk	(clk),
		.rstn	(rstn),
		.bus	(as_bus.fsm)
	);

	cps_deglitch #(
		.CYCLES	(DEGLITCH_CYCLES)
	) u_deglitch (
		.clk	(clk),
		.rstn	(rstn),
		.din	(sw_state == cps_pkg::SW_LIMIT),
		.dout	(cl_long)
	);

	// switch state machine
	always_comb begin
		next_sw = sw_state;
		case (sw_state)
		cps_pkg::SW_OFF:
			if (allowed && !temp_upper_hot)
				next_sw = overcurrent ? cps_pkg::SW_LIMIT : cps_pkg::SW_ON;
		cps_pkg::SW_ON:
			if (temp_upper_hot) next_sw = cps_pkg::SW_THERMAL;
			else if (!allowed) next_sw = cps_pkg::SW_OFF;
			else if (overcurrent) next_sw = cps_pkg::SW_LIMIT;
		cps_pkg::SW_LIMIT:
			if (ot_trip) next_sw = cps_pkg::SW_THERMAL;
			else if (!allowed) next_sw = cps_pkg::SW_OFF;
			else if (!overcurrent) next_sw = cps_pkg::SW_ON;
		cps_pkg::SW_THERMAL:
			if (!temp_upper_hot && !temp_lower_hot) next_sw = cps_pkg::SW_OFF;
		default: next_sw = cps_pkg::SW_OFF;
		endcase
	end

	assign next_fault = (next_sw == cps_pkg::SW_THERMAL) || cl_long;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sw_state <= cps_pkg::SW_OFF;
			mode_q <= cps_pkg::MODE_DISCHARGE;
			power_ok <= 1'b0;
		end else begin
			sw_state <= next_sw;
			mode_q <= mode;
			power_ok <= next_power_ok;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			disch_cnt <= '0;
		else if (mode_chg)
			disch_cnt <= DISCH_LOAD;
		else if (disch_cnt != '0)
			disch_cnt <= disch_cnt - DW'(1);
	end

	// pin outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			switch_on <= 1'b0;
			current_limiting <= 1'b0;
			upper_current_threshold <= 1'b0;
			vbus_discharge <= 1'b0;
			port_mode <= 3'h0;
			fault_n_out <= 1'b0;
			fault_n_oe_n <= 1'b1;
		end else begin
			switch_on <= (next_sw == cps_pkg::SW_ON) || (next_sw == cps_pkg::SW_LIMIT);
			current_limiting <= (next_sw == cps_pkg::SW_LIMIT);
			upper_current_threshold <= next_upper;
			vbus_discharge <= next_disch;
			port_mode <= as_bus.present_std ? cps_pkg::MODE_STD_DATA_2 : mode;
			fault_n_out <= 1'b0;
			fault_n_oe_n <= !next_fault;
		end
	end

	// interrupt events
	assign events[`CPS_INT_FAULT] = next_fault && fault_n_oe_n;
	assign events[`CPS_INT_THERMAL] = (next_sw == cps_pkg::SW_THERMAL) &&
		(sw_state != cps_pkg::SW_THERMAL);
	assign events[`CPS_INT_FALLBACK] = as_bus.fallback_evt;
	assign events[`CPS_INT_SUPPLY] = power_ok && !next_power_ok;
	assign events[`CPS_INT_MODE] = mode_chg;

	// avalon slave, one wait cycle per access
	assign acc = (avs_read || avs_write) && avs_waitrequest;
	assign wr = avs_write && !avs_waitrequest;
	assign rd_int = avs_read && !avs_waitrequest &&
		(avs_address == `CPS_REG_INT_STATUS);
	assign clr_bits = rd_int ? avs_readdata[IW-1:0] : '0;
	assign next_int = (int_status & ~clr_bits) | events;

	assign status_word = {21'h0, as_bus.present_std, !fault_n_oe_n, vbus_discharge,
		power_ok, (sw_state == cps_pkg::SW_THERMAL), current_limiting, switch_on,
		upper_current_threshold, port_mode};

	assign rd_mux = (avs_address == `CPS_REG_CTRL) ? {31'h0, ctrl_en} :
		(avs_address == `CPS_REG_STATUS) ? status_word :
		(avs_address == `CPS_REG_INT_STATUS) ? {{(32-IW){1'b0}}, int_status} :
		(avs_address == `CPS_REG_INT_MASK) ? {{(32-IW){1'b0}}, int_mask} : 32'h0;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			avs_waitrequest <= !acc;
			if (acc)
				avs_readdata <= avs_read ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_en <= `CPS_CTRL_EN_RESET;
			int_mask <= `CPS_INT_MASK_RESET;
		end else if (wr && avs_address == `CPS_REG_CTRL)
			ctrl_en <= avs_writedata[`CPS_CTRL_EN_BIT];
		else if (wr && avs_address == `CPS_REG_INT_MASK)
			int_mask <= avs_writedata[IW-1:0];
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_status <= '0;
			irq <= 1'b0;
		end else begin
			int_status <= next_int;
			irq <= |(next_int & int_mask);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_FALLBACK: assert property (as_bus.fallback_evt |-> ##2 (vbus_discharge && !switch_on
		&& port_mode == 3'(cps_pkg::MODE_STD_DATA_2)))
		else $error("fallback did not discharge and present standard data");
	AST_SHORT_START: assert property (sw_state == cps_pkg::SW_OFF && allowed && overcurrent
		&& !temp_upper_hot |=> current_limiting && switch_on)
		else $error("shorted start did not enter limiting");
	sequence s_cooled;
		sw_state == cps_pkg::SW_THERMAL && !temp_upper_hot && !temp_lower_hot
		##1 sw_state == cps_pkg::SW_OFF && allowed && !temp_upper_hot;
	endsequence
	AST_RESTART: assert property (s_cooled |=> switch_on)
		else $error("switch did not restart after cooling");
	AST_LOWER_TRIP: assert property (sw_state == cps_pkg::SW_LIMIT && temp_lower_hot
		|=> sw_state == cps_pkg::SW_THERMAL && !switch_on)
		else $error("lower sensor in limit did not switch off");
	AST_UPPER_TRIP: assert property (switch_on && temp_upper_hot
		|=> !switch_on && !fault_n_oe_n)
		else $error("upper sensor did not switch off and flag at once");
	AST_FAULT_HOLD: assert property (sw_state == cps_pkg::SW_THERMAL |-> !fault_n_oe_n)
		else $error("fault released during over-temperature");
	AST_FAULT_FREE: assert property (sw_state == cps_pkg::SW_ON && !cl_long
		&& !temp_upper_hot |=> fault_n_oe_n)
		else $error("fault held with no cause");
	AST_SUPPLY: assert property (supply_below_off |=> ##1 !switch_on)
		else $error("switch on with supply low");
	AST_THRESHOLD: assert property (mode == cps_pkg::MODE_CHARGER_AUTO
		|=> upper_current_threshold)
		else $error("auto charger mode not on upper threshold");
	AST_PAIR: assert property (pair_q && pair_now && disch_cnt == '0
		&& !as_bus.discharge_req |=> !vbus_discharge)
		else $error("discharge between paired codes");
endmodule
`default_nettype wire

// >>> tb/charge_port_switch_supervisor_bench.sv
// self-checking bench of the charge port supervisor
// assumes the design sources and the handset model are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.svh"
module charge_port_switch_supervisor_bench;
	localparam int	DG = 4;
	logic		clk = 1'b0;
	logic		rstn = 1'b0;
	logic [3:0]	avs_address = 4'h0;
	logic		avs_read = 1'b0;
	logic		avs_write = 1'b0;
	logic [31:0]	avs_writedata = 32'h0;
	logic [31:0]	avs_readdata, rd;
	logic		avs_waitrequest, irq, switch_on, current_limiting, upper_thr;
	logic		vbus_discharge, fault_n_out, fault_n_oe_n, attached, connected;
	logic [2:0]	port_mode;
	logic [3:0]	code = 4'h0;
	logic		plug = 1'b0;
	logic		overcurrent = 1'b0;
	logic		lower_hot = 1'b0;
	logic		upper_hot = 1'b0;
	logic		above_on = 1'b1;
	logic		below_off = 1'b0;
	int		n_errors = 0;
	int		n_checks = 0;
	int		cyc = 0;
	int		nd = 0;
	int		nf = 0;
	int		lc = 0;
	int		c0;
	// rows: pin code, presented mode, upper threshold
	logic [7:0]	rows [16] = '{8'h00, 8'h10, 8'h23, 8'h33, 8'h44, 8'h55, 8'h63, 8'h73,
				      8'h86, 8'h97, 8'ha8, 8'hb9, 8'hc4, 8'hd5, 8'hea, 8'hfd};

	always #50 clk = ~clk;

	cps_supervisor #(.DEGLITCH_CYCLES(DG), .NOCONN_CYCLES(20), .DISCH_CYCLES(10)) dut_u (
		.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .mode_select_0(code[3]),
		.mode_select_1(code[2]), .mode_select_2(code[1]), .limit_threshold_select(code[0]),
		.overcurrent(overcurrent), .temp_lower_hot(lower_hot), .temp_upper_hot(upper_hot),
		.supply_above_on(above_on), .supply_below_off(below_off),
		.port_attached(attached), .data_connected(connected), .switch_on(switch_on),
		.current_limiting(current_limiting), .upper_current_threshold(upper_thr),
		.vbus_discharge(vbus_discharge), .port_mode(port_mode),
		.fault_n_out(fault_n_out), .fault_n_oe_n(fault_n_oe_n));

	cps_handset #(.DELAY(3)) phone_u (
		.clk(clk), .rstn(rstn), .plug(plug), .port_mode(port_mode),
		.switch_on(switch_on), .port_attached(attached), .data_connected(connected));

	always @(posedge clk) begin
		cyc <= cyc + 1;
		nd <= nd + (vbus_discharge === 1'b1);
		nf <= nf + (fault_n_oe_n === 1'b0);
		lc <= (current_limiting === 1'b1) ? lc + 1 : 0;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		chk(n < 20, 1'b1, "bus answer");
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_for(input int sel, input logic v);
		int n;
		logic s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			case (sel)
			0: s = switch_on;
			1: s = vbus_discharge;
			2: s = connected;
			3: s = port_mode == 3'h6;
			default: s = fault_n_oe_n;
			endcase
		end while (s !== v && n < 200);
		chk(s, v, "wait");
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		chk({avs_waitrequest, switch_on, fault_n_oe_n, vbus_discharge, fault_n_out}, 5'h14,
			"reset");
		rstn <= 1'b1;
		@(posedge clk);
		bus(1'b0, `CPS_REG_CTRL, 32'h0);
		chk(rd, 32'h1, "ctrl reset");
		bus(1'b0, 4'h7, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bus(1'b1, `CPS_REG_INT_MASK, 32'h1f);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			code <= rows[i][7:4];
			repeat (16) @(posedge clk);
			chk(port_mode, rows[i][3:1], "mode");
			if (rows[i][3:1] != 3'h0) begin
				chk(upper_thr, rows[i][0], "threshold");
				chk(switch_on, 1'b1, "switch");
			end
		end
		@(posedge clk);
		chk(irq, 1'b1, "irq raised");
		bus(1'b0, `CPS_REG_INT_STATUS, 32'h0);
		chk(rd, 32'h10, "mode events");
		@(posedge clk);
		chk(irq, 1'b0, "irq cleared");
		$display("test modes done");
		for (int i = 0; i < 2; i++) begin
			c0 = nd;
			code <= i ? 4'hf : 4'he;
			repeat (16) @(posedge clk);
			chk(nd - c0, 0, "no discharge");
			chk(port_mode, i ? 3'h6 : 3'h5, "sdp2 cdp");
		end
		$display("test sdp2 cdp done");
		plug <= 1'b1;
		wait_for(1, 1'b1);
		chk({port_mode, switch_on}, 4'ha, "fallback");
		wait_for(2, 1'b1);
		c0 = nd;
		wait_for(3, 1'b1);
		chk(nd - c0, 0, "return");
		chk(switch_on, 1'b1, "kept on");
		bus(1'b0, `CPS_REG_STATUS, 32'h0);
		chk(rd, 32'h9e, "status back in charging data");
		bus(1'b0, `CPS_REG_INT_STATUS, 32'h0);
		chk(rd & 32'h4, 32'h4, "fallback event");
		plug <= 1'b0;
		$display("test fallback done");
		bus(1'b1, `CPS_REG_CTRL, 32'h0);
		overcurrent <= 1'b1;
		repeat (3) @(posedge clk);
		chk(switch_on, 1'b0, "disabled");
		bus(1'b1, `CPS_REG_CTRL, 32'h1);
		wait_for(0, 1'b1);
		chk(current_limiting, 1'b1, "short start");
		wait_for(4, 1'b0);
		chk(lc, DG + 1, "deglitch");
		repeat (5) @(posedge clk);
		chk(fault_n_oe_n, 1'b0, "held");
		overcurrent <= 1'b0;
		wait_for(4, 1'b1);
		c0 = nf;
		overcurrent <= 1'b1;
		repeat (2) @(posedge clk);
		overcurrent <= 1'b0;
		repeat (10) @(posedge clk);
		chk(nf - c0, 0, "glitch");
		$display("test limit done");
		overcurrent <= 1'b1;
		repeat (2) @(posedge clk);
		lower_hot <= 1'b1;
		repeat (2) @(posedge clk);
		chk({switch_on, fault_n_oe_n}, 2'b00, "lower trip");
		repeat (5) @(posedge clk);
		chk(switch_on, 1'b0, "cooling");
		lower_hot <= 1'b0;
		wait_for(0, 1'b1);
		overcurrent <= 1'b0;
		wait_for(4, 1'b1);
		upper_hot <= 1'b1;
		repeat (2) @(posedge clk);
		chk({switch_on, fault_n_oe_n}, 2'b00, "upper trip");
		upper_hot <= 1'b0;
		wait_for(0, 1'b1);
		bus(1'b0, `CPS_REG_INT_STATUS, 32'h0);
		chk(rd & 32'h2, 32'h2, "thermal event");
		$display("test thermal done");
		bus(1'b1, `CPS_REG_INT_MASK, 32'h0);
		above_on <= 1'b0;
		below_off <= 1'b1;
		repeat (3) @(posedge clk);
		chk({switch_on, irq}, 2'b00, "lockout");
		below_off <= 1'b0;
		repeat (5) @(posedge clk);
		chk(switch_on, 1'b0, "hysteresis");
		bus(1'b1, `CPS_REG_INT_MASK, 32'h8);
		@(posedge clk);
		chk(irq, 1'b1, "supply irq");
		bus(1'b0, `CPS_REG_INT_STATUS, 32'h0);
		chk(rd & 32'h8, 32'h8, "supply event");
		@(posedge clk);
		chk(irq, 1'b0, "irq clear");
		above_on <= 1'b1;
		wait_for(0, 1'b1);
		$display("test supply done");
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> tb/cps_handset.sv
// model of an attached handset that charges on any port but links for data
// only once it sees a powered standard data port
// assumes the port_mode encoding of the supervisor and one shared clock
`timescale 1ns/100ps
`default_nettype none
module cps_handset #(
	parameter int DELAY = 3
) (
	input	wire logic		clk,
	input	wire logic		rstn,
	input	wire logic		plug,
	input	wire logic [2:0]	port_mode,
	input	wire logic		switch_on,
	output	wire logic		port_attached,
	output	wire logic		data_connected
);
	int	cnt;
	logic	std_seen;
	assign std_seen = (port_mode == 3'h5 || port_mode == 3'h2) && switch_on;
	always_ff @(posedge clk) begin
		if (!rstn || !plug) begin
			cnt <= 0;
		end else if (std_seen && cnt < DELAY) begin
			cnt <= cnt + 1;
		end
	end
	assign port_attached = plug;
	assign data_connected = plug && cnt >= DELAY;
endmodule
`default_nettype wire
